// [trace_trigger_sequencer.sv]
/*
  State-trace sequencer: qualifies each captured bus state, steps through the
  sequence levels, decides which states enter the trace buffer and reports
  trigger, completion and a break request.
  Assumes st_valid, st_data, pattern_hit and range_hit come from comparators
  on mclk; arm_pin is asynchronous and is synchronised here.
*/
`timescale 1ns/100ps

// Function
// - Two-term: enable condition advances to level two
// - Level one stores enable-store matches only
// - Level two stores trigger-store matches only
// - After trigger store post-trigger matches only
// - Restart match before trigger returns sequence to first level
// - Counter counts time, occurrences, or is off
// - Up to two prestored states per stored state
// - Start placement: trigger first, earlier states dropped
// - Centre placement: states kept before and after
// - End placement: trigger last, no later stores
// - Break request pulses at trigger when enabled
// - Eight levels, each with branches, destinations, store
// - Multilevel starts at level one, waits branch
// - Branch moves to its programmed destination level
// - Primary branch wins when both match
// - Trigger on entry into trigger level
// - Multilevel stores current level's qualifier matches
// - Sequenced trace completes once its post-trigger stores are made
// - Free-running trace stores until stopped
// - Stop ends any trace; buffer becomes readable
// - Every captured state is qualified, prefetches included
// - Conditions combine patterns, range, arm with operators
// - Condition met after programmed occurrence count
module trace_trigger_sequencer #(
  parameter int STATE_W = 32,
  parameter int BUF_AW = 6,
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite register slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Observed bus states and comparator results
  input wire logic st_valid,
  input wire logic [STATE_W-1:0] st_data,
  input wire logic [7:0] pattern_hit,
  input wire logic range_hit,
  input wire logic arm_pin,
  // Trace status
  output logic trace_running,
  output logic trace_trigger,
  output logic trace_done,
  output logic break_req
);
  localparam int DEPTH = 1 << BUF_AW;
  localparam int NC = trace_seq_pkg::NCOND;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge

  // Set1 is the pattern group, set2 the range and arm group.
  function automatic logic cond_hit(input logic [31:0] c, input logic [7:0] pat,
                                    input logic rh, input logic arm);
    logic s1;
    logic s2;
    s1 = (|(c[7:0] & pat)) ^ c[trace_seq_pkg::CF_NOR];
    s2 = (c[trace_seq_pkg::CF_RANGE] & rh) | (c[trace_seq_pkg::CF_NOT_RANGE] & ~rh) |
         (c[trace_seq_pkg::CF_ARM] & arm);
    return c[trace_seq_pkg::CF_ANY] | (c[trace_seq_pkg::CF_AND] ? (s1 & s2) : (s1 | s2));
  endfunction : cond_hit

  function automatic logic [2:0] pick3(input logic [23:0] v, input logic [2:0] i);
    return v[3*i +: 3];
  endfunction : pick3

  // Arm pin synchroniser.
  logic arm_meta;
  logic arm_lvl;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      arm_meta <= 1'b0;
      arm_lvl <= 1'b0;
    end
    else
    begin
      arm_meta <= arm_pin;
      arm_lvl <= arm_meta;
    end
  end

  // Software-visible configuration and sequencer state.
  trace_seq_pkg::mode_t mode;
  trace_seq_pkg::place_t place;
  trace_seq_pkg::cnt_mode_t cnt_mode;
  trace_seq_pkg::run_state_t state;
  logic break_en;
  logic [2:0] trig_lvl;
  logic [23:0] dest_pri;
  logic [23:0] dest_sec;
  logic [31:0] rd_index;
  logic [31:0] cond [NC];
  logic [15:0] occ [NC];
  logic [CNT_W-1:0] counter;
  logic [2:0] level;
  logic triggered;
  logic [BUF_AW:0] fill;
  logic [BUF_AW:0] left;
  logic [BUF_AW-1:0] wptr;
  logic [STATE_W-1:0] tbuf [DEPTH];
  logic [STATE_W-1:0] pre [trace_seq_pkg::PRESTORE_MAX];
  logic [1:0] pcnt;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Write decode; a write executes once both address and data are held.
  wire wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire [11:0] wc = aw_addr - trace_seq_pkg::REG_COND_BASE;
  wire w_cond = aw_addr >= trace_seq_pkg::REG_COND_BASE && wc[11:2] < 10'(NC) && wc[1:0] == 2'h0;
  wire [4:0] w_cidx = wc[6:2];
  wire w_ctrl = aw_addr == trace_seq_pkg::REG_CTRL;
  wire w_trig = aw_addr == trace_seq_pkg::REG_TRIG_LVL;
  wire w_dpri = aw_addr == trace_seq_pkg::REG_DEST_PRI;
  wire w_dsec = aw_addr == trace_seq_pkg::REG_DEST_SEC;
  wire w_ridx = aw_addr == trace_seq_pkg::REG_RD_INDEX;
  wire w_hit = w_cond | w_ctrl | w_trig | w_dpri | w_dsec | w_ridx;
  wire [31:0] ctrl_new = merge(32'h0000_0000, w_data, w_strb);
  wire start_cmd = wr_go & w_ctrl & ctrl_new[trace_seq_pkg::CTRL_START];
  wire stop_cmd = wr_go & w_ctrl & ctrl_new[trace_seq_pkg::CTRL_STOP] & ~start_cmd;

  // Condition evaluation with occurrence counts.
  logic [NC-1:0] raw;
  logic [NC-1:0] sat;
  for (genvar k = 0; k < NC; k++)
  begin : g_cond
    assign raw[k] = cond_hit(cond[k], pattern_hit, range_hit, arm_lvl);
    assign sat[k] = raw[k] && ({1'b0, occ[k]} + 17'h00001 >=
                    {1'b0, cond[k][trace_seq_pkg::CF_COUNT_LSB +: 16]});
  end

  // Sequencing decisions for the present captured state.
  wire sample = st_valid && state == trace_seq_pkg::ST_RUN;
  wire two = mode == trace_seq_pkg::MODE_TWO;
  wire multi = mode == trace_seq_pkg::MODE_MULTI;
  wire free = mode == trace_seq_pkg::MODE_FREE;
  wire prim = sat[trace_seq_pkg::COND_PRI + int'(level)];
  wire sec = sat[trace_seq_pkg::COND_SEC + int'(level)];
  wire [2:0] dp = two ? level + 3'h1 : pick3(dest_pri, level);
  wire [2:0] ds = pick3(dest_sec, level);
  wire use_pri = multi ? prim : (two && level < 3'h2 && prim);
  wire use_sec = multi && sec;
  wire restart = two && !triggered && sat[trace_seq_pkg::COND_RESTART];
  wire [2:0] next_level = restart ? 3'h0 : use_pri ? dp : use_sec ? ds : level;
  wire [2:0] eff_trig = two ? 3'h2 : trig_lvl;
  wire trig_now = sample && !free && !triggered && next_level != level &&
                  next_level == eff_trig;
  // Level stores: enable, trigger and post-trigger qualifiers in two-term mode.
  wire store_q = free | sat[trace_seq_pkg::COND_STO + int'(level)];
  wire at_start = place == trace_seq_pkg::PLACE_START;
  wire at_end = place == trace_seq_pkg::PLACE_END;
  wire want = sample && (free || trig_now ||
              (!triggered && store_q && !at_start) ||
              (triggered && store_q && !at_end));
  wire [1:0] c_eff = (trig_now && at_start) ? 2'h0 : pcnt;
  wire [BUF_AW:0] n = want ? {{(BUF_AW-1){1'b0}}, c_eff} + {{BUF_AW{1'b0}}, 1'b1} : '0;
  wire [BUF_AW:0] nw = (triggered && n > left) ? left : n;
  wire [BUF_AW:0] skip = n - nw;
  wire [BUF_AW:0] post_len = at_start ? (BUF_AW+1)'(DEPTH - 1) :
                             at_end ? '0 : (BUF_AW+1)'(DEPTH / 2);
  wire [BUF_AW:0] fill_base = (trig_now && at_start) ? '0 : fill;
  wire [BUF_AW+1:0] fill_sum = {1'b0, fill_base} + {1'b0, nw};
  wire [BUF_AW:0] next_fill = fill_sum > (BUF_AW+2)'(DEPTH) ? (BUF_AW+1)'(DEPTH) :
                              fill_sum[BUF_AW:0];
  wire finish = sample && !free && ((trig_now && at_end) ||
                (triggered && left == nw));

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= trace_seq_pkg::ST_IDLE;
      level <= 3'h0;
      triggered <= 1'b0;
      fill <= '0;
      left <= '0;
      wptr <= '0;
      pcnt <= 2'h0;
      counter <= '0;
    end
    else
    begin
      case (state)
        trace_seq_pkg::ST_IDLE, trace_seq_pkg::ST_DONE:
        begin
          if (start_cmd)
          begin
            state <= trace_seq_pkg::ST_RUN;
            level <= 3'h0;
            triggered <= 1'b0;
            fill <= '0;
            pcnt <= 2'h0;
            counter <= '0;
          end
        end
        trace_seq_pkg::ST_RUN:
        begin
          if (!start_cmd && (stop_cmd || finish))
            state <= trace_seq_pkg::ST_DONE;
          if (start_cmd)
          begin
            level <= 3'h0;
            triggered <= 1'b0;
            fill <= '0;
            pcnt <= 2'h0;
            counter <= '0;
          end
          else
          begin
            if (cnt_mode == trace_seq_pkg::CNT_TIME ||
                (cnt_mode == trace_seq_pkg::CNT_OCCUR && sample &&
                 raw[trace_seq_pkg::COND_CNT]))
              counter <= counter + CNT_W'(1);
            if (sample)
            begin
              level <= next_level;
              fill <= next_fill;
              wptr <= wptr + nw[BUF_AW-1:0];
              if (trig_now)
              begin
                triggered <= 1'b1;
                left <= post_len;
              end
              else if (triggered)
                left <= left - nw;
              if (want)
                pcnt <= 2'h0;
              else if (!free && sat[trace_seq_pkg::COND_PRE] && pcnt != 2'h2)
                pcnt <= pcnt + 2'h1;
            end
          end
        end
        default:
          state <= trace_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Prestore history and buffer writes; storage has no reset.
  always_ff @(posedge mclk)
  begin
    if (sample && !want && !free && sat[trace_seq_pkg::COND_PRE])
    begin
      if (pcnt == 2'h2)
      begin
        pre[0] <= pre[1];
        pre[1] <= st_data;
      end
      else
        pre[pcnt[0]] <= st_data;
    end
    for (int j = 0; j < 3; j++)
    begin
      if (sample && j >= int'(skip) && j < int'(n))
        tbuf[wptr + BUF_AW'(j - int'(skip))] <= (j < int'(c_eff)) ? pre[j[0]] : st_data;
    end
  end

  // Occurrence counters restart on trace start and on each level change.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int k = 0; k < NC; k++)
        occ[k] <= 16'h0000;
    end
    else
    begin
      for (int k = 0; k < NC; k++)
      begin
        if (start_cmd || (sample && next_level != level) || (sample && sat[k]))
          occ[k] <= 16'h0000;
        else if (sample && raw[k])
          occ[k] <= occ[k] + 16'h0001;
      end
    end
  end

  // Register writes and write response.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= trace_seq_pkg::RESP_OKAY;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      mode <= trace_seq_pkg::MODE_FREE;
      place <= trace_seq_pkg::PLACE_START;
      cnt_mode <= trace_seq_pkg::CNT_OFF;
      break_en <= 1'b0;
      trig_lvl <= trace_seq_pkg::TRIG_LVL_RST;
      dest_pri <= trace_seq_pkg::DEST_RST;
      dest_sec <= trace_seq_pkg::DEST_RST;
      rd_index <= 32'h0000_0000;
      for (int k = 0; k < NC; k++)
        cond[k] <= trace_seq_pkg::COND_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_wready <= 1'b1;
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? trace_seq_pkg::RESP_OKAY : trace_seq_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go && w_ctrl)
      begin
        mode <= trace_seq_pkg::mode_t'(ctrl_new[trace_seq_pkg::CTRL_MODE_LSB +: 2]);
        place <= trace_seq_pkg::place_t'(ctrl_new[trace_seq_pkg::CTRL_PLACE_LSB +: 2]);
        break_en <= ctrl_new[trace_seq_pkg::CTRL_BREAK];
        cnt_mode <= trace_seq_pkg::cnt_mode_t'(ctrl_new[trace_seq_pkg::CTRL_COUNT_LSB +: 2]);
      end
      if (wr_go && w_trig)
        trig_lvl <= w_data[2:0];
      if (wr_go && w_dpri)
        dest_pri <= 24'(merge({8'h00, dest_pri}, w_data, w_strb));
      if (wr_go && w_dsec)
        dest_sec <= 24'(merge({8'h00, dest_sec}, w_data, w_strb));
      if (wr_go && w_ridx)
        rd_index <= merge(rd_index, w_data, w_strb);
      if (wr_go && w_cond)
        cond[w_cidx] <= merge(cond[w_cidx], w_data, w_strb);
    end
  end

  // Read decode; entries are read oldest first by index.
  wire [11:0] ra = s_axi_araddr;
  wire [11:0] rc = ra - trace_seq_pkg::REG_COND_BASE;
  wire r_cond = ra >= trace_seq_pkg::REG_COND_BASE && rc[11:2] < 10'(NC) && rc[1:0] == 2'h0;
  wire [BUF_AW-1:0] rd_ptr = wptr - fill[BUF_AW-1:0] + rd_index[BUF_AW-1:0];
  wire [31:0] status_word = {(15-BUF_AW)'(0), fill, 10'h000, level,
                             trace_done, trace_trigger, trace_running};
  wire [31:0] ctrl_word = {23'h000000, cnt_mode, break_en, place, mode, 2'h0};
  wire r_hit = r_cond || ra == trace_seq_pkg::REG_CTRL || ra == trace_seq_pkg::REG_STATUS ||
               ra == trace_seq_pkg::REG_TRIG_LVL || ra == trace_seq_pkg::REG_DEST_PRI ||
               ra == trace_seq_pkg::REG_DEST_SEC || ra == trace_seq_pkg::REG_COUNTER ||
               ra == trace_seq_pkg::REG_RD_INDEX || ra == trace_seq_pkg::REG_RD_DATA;
  wire [31:0] rd_word =
    r_cond ? cond[rc[6:2]] :
    ra == trace_seq_pkg::REG_CTRL ? ctrl_word :
    ra == trace_seq_pkg::REG_STATUS ? status_word :
    ra == trace_seq_pkg::REG_TRIG_LVL ? {29'h0, trig_lvl} :
    ra == trace_seq_pkg::REG_DEST_PRI ? {8'h00, dest_pri} :
    ra == trace_seq_pkg::REG_DEST_SEC ? {8'h00, dest_sec} :
    ra == trace_seq_pkg::REG_COUNTER ? 32'(counter) :
    ra == trace_seq_pkg::REG_RD_INDEX ? rd_index :
    ra == trace_seq_pkg::REG_RD_DATA ? 32'(tbuf[rd_ptr]) : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= trace_seq_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= r_hit ? trace_seq_pkg::RESP_OKAY : trace_seq_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Status outputs.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      trace_running <= 1'b0;
      trace_trigger <= 1'b0;
      trace_done <= 1'b0;
      break_req <= 1'b0;
    end
    else
    begin
      trace_running <= start_cmd || (state == trace_seq_pkg::ST_RUN && !stop_cmd && !finish);
      trace_trigger <= !start_cmd && (trace_trigger || trig_now);
      trace_done <= !start_cmd && (trace_done || (state == trace_seq_pkg::ST_RUN &&
                    (stop_cmd || finish)));
      break_req <= trig_now && break_en;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_break_on_trig: assert property (trig_now && break_en |=> break_req)
    else $error("break request missing at trigger");
  a_break_cause: assert property (break_req |-> $past(trig_now) && $past(break_en))
    else $error("break request without trigger");
  a_stop_ends: assert property (stop_cmd && state == trace_seq_pkg::ST_RUN
                                |=> !trace_running && trace_done)
    else $error("stop did not end the trace");
  a_restart_lvl: assert property (sample && restart && !start_cmd |=> level == 3'h0)
    else $error("restart did not return to level one");
  a_enable_adv: assert property (sample && two && level == 3'h0 && prim && !restart &&
                                 !start_cmd |=> level == 3'h1)
    else $error("enable did not advance the level");
  a_primary_wins: assert property (sample && multi && prim && sec && !start_cmd
                                   |=> level == $past(dp))
    else $error("primary branch not taken");
  a_level_hold: assert property (sample && multi && !prim && !sec && !start_cmd
                                 |=> $stable(level))
    else $error("level moved without a branch");
  a_trig_entry: assert property (trig_now && !start_cmd
                                 |=> trace_trigger && level == $past(eff_trig))
    else $error("trigger not raised on level entry");
  a_end_stop: assert property (trig_now && at_end && !start_cmd
                               |=> state == trace_seq_pkg::ST_DONE ##1 trace_done)
    else $error("end placement did not finish at trigger");
  a_free_store: assert property (sample && free && !start_cmd && fill < (BUF_AW+1)'(DEPTH)
                                 |=> fill == $past(fill) + (BUF_AW+1)'(1))
    else $error("free-running trace skipped a state");
  a_fill_max: assert property (fill <= (BUF_AW+1)'(DEPTH))
    else $error("fill count beyond depth");

  c_center_trig: cover property (trig_now && place == trace_seq_pkg::PLACE_CENTER);
  c_full_done: cover property (finish && at_start);
  c_prestore_two: cover property (pcnt == 2'h2 && want);
  c_stop_run: cover property (stop_cmd && free);
endmodule : trace_trigger_sequencer

// [trace_seq_pkg.sv]
/*
  Constants, register map and types of the state-trace sequencer.
  Assumes a 32-bit AXI4-Lite register bus with 12 address bits.
*/
package trace_seq_pkg;
  // Sequence levels and condition table layout.
  localparam int NLEVEL = 8;
  localparam int NCOND = 27;
  localparam int COND_PRI = 0;
  localparam int COND_SEC = 8;
  localparam int COND_STO = 16;
  localparam int COND_RESTART = 24;
  localparam int COND_PRE = 25;
  localparam int COND_CNT = 26;
  localparam int PRESTORE_MAX = 2;
  // Register byte offsets.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TRIG_LVL = 12'h008;
  localparam logic [11:0] REG_DEST_PRI = 12'h00C;
  localparam logic [11:0] REG_DEST_SEC = 12'h010;
  localparam logic [11:0] REG_COUNTER = 12'h014;
  localparam logic [11:0] REG_RD_INDEX = 12'h018;
  localparam logic [11:0] REG_RD_DATA = 12'h01C;
  localparam logic [11:0] REG_COND_BASE = 12'h100;
  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_PLACE_LSB = 4;
  localparam int CTRL_BREAK = 6;
  localparam int CTRL_COUNT_LSB = 7;
  // Condition word fields.
  localparam int CF_RANGE = 8;
  localparam int CF_NOT_RANGE = 9;
  localparam int CF_ARM = 10;
  localparam int CF_NOR = 11;
  localparam int CF_AND = 12;
  localparam int CF_ANY = 13;
  localparam int CF_COUNT_LSB = 16;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] TRIG_LVL_RST = 3'h2;
  localparam logic [23:0] DEST_RST = 24'h000000;
  localparam logic [31:0] COND_RST = 32'h0000_0000;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_FREE = 2'b00, MODE_TWO = 2'b01, MODE_MULTI = 2'b10} mode_t;
  typedef enum logic [1:0] {PLACE_START = 2'b00, PLACE_CENTER = 2'b01,
                            PLACE_END = 2'b10} place_t;
  typedef enum logic [1:0] {CNT_OFF = 2'b00, CNT_TIME = 2'b01, CNT_OCCUR = 2'b10} cnt_mode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_DONE = 2'b10} run_state_t;
endpackage : trace_seq_pkg

// [bus_state_source.sv]
/* Model of the observed processor bus: one state per cycle while go is high.
   Assumes go and pat change on the rising edge of mclk. */
`timescale 1ns/100ps
module bus_state_source (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bench control
  input wire logic go,
  input wire logic [7:0] pat,
  // Observed bus
  output logic st_valid,
  output logic [31:0] st_data,
  output logic [7:0] pattern_hit,
  output logic range_hit
);
  logic [31:0] idx;
  // Between states the lines change every cycle, so only st_valid qualifies them.
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn)
    begin
      idx <= 32'h0;
      st_valid <= 1'b0;
      st_data <= 32'h0;
      pattern_hit <= 8'h00;
      range_hit <= 1'b0;
    end
    else
    begin
      st_valid <= go;
      st_data <= go ? idx : ~st_data;
      pattern_hit <= go ? pat : ~pattern_hit;
      range_hit <= go ? 1'b0 : ~range_hit;
      idx <= go ? idx + 32'h1 : idx;
    end
endmodule : bus_state_source

// [tb_top.sv]
/* Testbench of the trace sequencer: register bus tasks and scenarios.
   Assumes the bus model feeds the observed-state inputs. */
`timescale 1ns/100ps
module tb_top;
  logic mclk = 1'b0, rstn = 1'b0, go = 1'b0, arm_pin = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, st_data, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] pat = 8'h00, pattern_hit;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic st_valid, range_hit, trace_running, trace_trigger, trace_done, break_req;
  int mismatches = 0, tests_run = 0, cyc = 0, nbrk = 0, idx = 0, t0;
  trace_trigger_sequencer #(.BUF_AW(3)) dut (.*);
  bus_state_source model (.*);
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    nbrk += int'(break_req === 1'b1);
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test;
    if (mismatches == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  task automatic cw(input int k, input logic [31:0] d);
    wr(trace_seq_pkg::REG_COND_BASE + 12'(4 * k), d);
  endtask : cw
  task automatic ctl(input logic [31:0] d);
    wr(trace_seq_pkg::REG_CTRL, d);
  endtask : ctl
  task automatic ent(input int i);
    wr(trace_seq_pkg::REG_RD_INDEX, 32'(i));
    rd(trace_seq_pkg::REG_RD_DATA);
  endtask : ent
  // Sends n back-to-back states with pattern p, then lets the flags settle.
  task automatic send(input logic [7:0] p, input int n);
    pat <= p;
    go <= 1'b1;
    repeat (n) @(posedge mclk);
    go <= 1'b0;
    idx += n;
    repeat (3) @(posedge mclk);
  endtask : send
  task automatic t_start;
    ctl(32'h45);
    chk("running", 32'h1, 32'(trace_running));
    send(8'h02, 1);
    send(8'h01, 1);
    rd(trace_seq_pkg::REG_STATUS);
    chk("level", 32'h1, 32'(v[5:3]));
    t0 = idx;
    send(8'h04, 1);
    chk("trigger", 32'h1, 32'(trace_trigger));
    send(8'h00, 7);
    chk("done", 32'h1, 32'(trace_done));
    chk("breaks", 32'h1, 32'(nbrk));
    rd(trace_seq_pkg::REG_STATUS);
    chk("fill", 32'h8, 32'(v[22:16]));
    ent(0);
    chk("first", 32'(t0), v);
  endtask : t_start
  task automatic t_end;
    ctl(32'h25);
    t0 = idx;
    send(8'h02, 1);
    send(8'h00, 1);
    send(8'h01, 1);
    send(8'h08, 1);
    send(8'h04, 1);
    rd(trace_seq_pkg::REG_STATUS);
    chk("fill", 32'h3, 32'(v[22:16]));
    chk("done", 32'h1, 32'(trace_done));
    chk("breaks", 32'h1, 32'(nbrk));
    ent(1);
    chk("lvl2 store", 32'(t0 + 3), v);
    ent(2);
    chk("last", 32'(t0 + 4), v);
  endtask : t_end
  task automatic t_center;
    cw(25, 32'h20);
    ctl(32'h15);
    t0 = idx;
    send(8'h02, 5);
    send(8'h20, 1);
    send(8'h02, 1);
    send(8'h01, 1);
    send(8'h04, 1);
    send(8'h00, 4);
    chk("done", 32'h1, 32'(trace_done));
    ent(1);
    chk("prestore", 32'(t0 + 5), v);
    ent(3);
    chk("centre trig", 32'(t0 + 8), v);
  endtask : t_center
  task automatic t_multi;
    wr(trace_seq_pkg::REG_DEST_PRI, 32'h3);
    wr(trace_seq_pkg::REG_DEST_SEC, 32'h5);
    wr(trace_seq_pkg::REG_TRIG_LVL, 32'h3);
    ctl(32'h09);
    rd(trace_seq_pkg::REG_STATUS);
    chk("level", 32'h0, 32'(v[5:3]));
    send(8'h01, 1);
    rd(trace_seq_pkg::REG_STATUS);
    chk("level", 32'h3, 32'(v[5:3]));
    chk("trigger", 32'h1, 32'(trace_trigger));
    ctl(32'h02);
  endtask : t_multi
  initial
  begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(trace_seq_pkg::REG_TRIG_LVL);
    chk("trig lvl", 32'h2, v);
    rd(12'h020);
    chk("bad addr", 32'(trace_seq_pkg::RESP_SLVERR), 32'(resp));
    cw(0, 32'h1);
    cw(8, 32'h1);
    cw(16, 32'h2);
    cw(1, 32'h4);
    cw(17, 32'h8);
    cw(18, 32'h2000);
    cw(24, 32'h10);
    t_start();
    t_end();
    t_center();
    ctl(32'h05);
    send(8'h01, 1);
    send(8'h10, 1);
    rd(trace_seq_pkg::REG_STATUS);
    chk("restart", 32'h0, 32'(v[5:3]));
    t_multi();
    cw(26, 32'h2000);
    ctl(32'h101);
    send(8'h00, 5);
    ctl(32'h02);
    rd(trace_seq_pkg::REG_STATUS);
    chk("free fill", 32'h5, 32'(v[22:16]));
    chk("stopped", 32'h4, 32'(v[2:0]));
    chk("running", 32'h0, 32'(trace_running));
    rd(trace_seq_pkg::REG_COUNTER);
    chk("count", 32'h5, v);
    stop_test();
  end
endmodule : tb_top
